// ### verilog/usb_interface_module.sv
// Flag, mask, status and transceiver control registers of the USB interface module
`timescale 1ns/1ps

module usb_interface_module #(
	parameter int FILT_WIDTH = 16
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [7:0]             reg_addr,
	input  wire logic [31:0]            reg_wdata,
	output logic      [31:0]            reg_rdata,
	output logic                        reg_rvalid,
	input  wire usb_ifm_pkg::utmi_in_t  utmi,
	input  wire usb_ifm_pkg::token_t    token,
	input  wire logic                   pkt_start,
	input  wire logic [3:0]             pkt_pid,
	input  wire logic                   crc16_fail,
	input  wire logic                   sof_valid,
	input  wire logic [10:0]            sof_frame,
	input  wire logic                   resume_se0,
	input  wire logic                   resume_k,
	output logic      [3:0]             flag_port,
	output logic      [4:0]             rx_endpoint,
	output logic                        rx_endpoint_strobe,
	output logic      [1:0]             linestate_filtered,
	output logic                        tx_se0,
	output logic                        tx_data,
	output logic                        tx_enable_sel,
	output logic                        fsls_serial,
	output logic                        pulldown_disable,
	output logic                        resume_auto_en,
	output logic      [2:0]             transceiver_config_pins
);

	////////////////////////////////////////////////////////////////////////
	// Register state

	logic        soft_rst;
	logic [6:0]  device_address;
	logic [5:0]  otg_status_flags;
	logic [2:0]  rx_line_status;
	logic [3:0]  serial_line_control;
	logic [6:0]  event_flag_vector;
	logic [6:0]  flag_stickiness_select;
	logic [31:0] flag_port_masks;
	logic [10:0] frame_counter;
	logic [3:0]  last_packet_id;
	logic [4:0]  last_endpoint;
	logic [15:0] endpoint_special_mask;
	logic [31:0] otg_event_mask;
	logic [8:0]  power_signal_word;
	logic        res_se0;
	logic        res_k;
	logic [3:0]  filt_log2;
	logic [1:0]  ls_cand;
	logic [FILT_WIDTH-1:0] ls_count;

	////////////////////////////////////////////////////////////////////////
	// Decode

	// Module state reset covers the soft reset, which spares only the read data path
	wire state_rst = rst | soft_rst;
	wire wr_reset  = reg_wr && reg_addr == usb_ifm_pkg::OFF_MODULE_RESET;
	wire wr_addr   = reg_wr && reg_addr == usb_ifm_pkg::OFF_DEVICE_ADDRESS;
	wire wr_serial = reg_wr && reg_addr == usb_ifm_pkg::OFF_SERIAL_LINE;
	wire wr_flags  = reg_wr && reg_addr == usb_ifm_pkg::OFF_EVENT_FLAGS;
	wire wr_sticky = reg_wr && reg_addr == usb_ifm_pkg::OFF_FLAG_STICKINESS;
	wire wr_masks  = reg_wr && reg_addr == usb_ifm_pkg::OFF_FLAG_PORT_MASKS;
	wire wr_frame  = reg_wr && reg_addr == usb_ifm_pkg::OFF_FRAME_COUNTER;
	wire wr_spec   = reg_wr && reg_addr == usb_ifm_pkg::OFF_ENDPOINT_SPECIAL;
	wire wr_otgm   = reg_wr && reg_addr == usb_ifm_pkg::OFF_OTG_EVENT_MASK;
	wire wr_power  = reg_wr && reg_addr == usb_ifm_pkg::OFF_POWER_SIGNAL;
	wire wr_xcvr   = reg_wr && reg_addr == usb_ifm_pkg::OFF_XCVR_CONTROL;

	// Token accepted only for our address
	wire token_ok = token.valid & token.crc5_ok & token.pid_ok
		& (token.addr == device_address);

	////////////////////////////////////////////////////////////////////////
	// Line state filter

	// Candidate must hold for 2^N clocks; a glitch restarts the count
	wire [FILT_WIDTH-1:0] filt_target = FILT_WIDTH'(1) << filt_log2;
	wire                  ls_differs  = utmi.linestate != ls_cand;
	wire                  ls_settled  = ls_count >= filt_target;

	always_ff @(posedge core_clk) begin
		if (state_rst) begin
			ls_cand            <= usb_ifm_pkg::LS_J;
			ls_count           <= '0;
			linestate_filtered <= usb_ifm_pkg::LS_J;
		end else if (ls_differs) begin
			ls_cand  <= utmi.linestate;
			ls_count <= FILT_WIDTH'(1);
		end else if (ls_settled) begin
			linestate_filtered <= ls_cand;
		end else begin
			ls_count <= ls_count + FILT_WIDTH'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event flags

	// Sources in flag order; line symbols come from the filtered state
	wire [6:0] flag_src = {
		token_ok,
		linestate_filtered == usb_ifm_pkg::LS_SE0,
		linestate_filtered == usb_ifm_pkg::LS_K,
		linestate_filtered == usb_ifm_pkg::LS_J,
		crc16_fail,
		utmi.rx_active,
		utmi.rx_error
	};

	// Sticky bits clear only by a written one, and a new event beats that clear
	genvar gi;
	generate
		for (gi = 0; gi < usb_ifm_pkg::NUM_FLAGS; gi++) begin : g_flag
			wire sw_clr = wr_flags & reg_wdata[gi];
			wire next_sticky = flag_src[gi] | (event_flag_vector[gi] & ~sw_clr);
			wire next_normal = usb_ifm_pkg::LEVEL_FLAGS[gi] ? flag_src[gi]
				: flag_src[gi] | (event_flag_vector[gi] & ~pkt_start);
			always_ff @(posedge core_clk) begin
				if (state_rst)
					event_flag_vector[gi] <= 1'b0;
				else if (flag_stickiness_select[gi])
					event_flag_vector[gi] <= next_sticky;
				else
					event_flag_vector[gi] <= next_normal;
			end
		end
	endgenerate

	// Each port is the OR of the flags its mask selects
	wire [3:0] next_flag_port = {
		|(event_flag_vector & flag_port_masks[30:24]),
		|(event_flag_vector & flag_port_masks[22:16]),
		|(event_flag_vector & flag_port_masks[14:8]),
		|(event_flag_vector & flag_port_masks[6:0])
	};

	////////////////////////////////////////////////////////////////////////
	// Software registers

	always_ff @(posedge core_clk) begin
		if (rst)
			soft_rst <= 1'b0;
		else
			soft_rst <= wr_reset;
	end

	// Writable configuration; reserved bits are simply not stored
	always_ff @(posedge core_clk) begin
		if (state_rst) begin
			device_address         <= '0;
			serial_line_control    <= usb_ifm_pkg::SER_RESET;
			flag_stickiness_select <= '0;
			flag_port_masks        <= '0;
			endpoint_special_mask  <= '0;
			otg_event_mask         <= '0;
			power_signal_word      <= '0;
			pulldown_disable       <= 1'b0;
			filt_log2              <= '0;
			resume_auto_en         <= 1'b0;
			transceiver_config_pins <= '0;
		end else begin
			if (wr_addr)
				device_address <= reg_wdata[6:0];
			if (wr_serial)
				serial_line_control <= reg_wdata[3:0];
			if (wr_sticky)
				flag_stickiness_select <= reg_wdata[6:0];
			if (wr_masks)
				flag_port_masks <= reg_wdata & 32'h7f7f7f7f;
			if (wr_spec)
				endpoint_special_mask <= reg_wdata[15:0];
			if (wr_otgm)
				otg_event_mask <= reg_wdata;
			if (wr_power)
				power_signal_word <= reg_wdata[usb_ifm_pkg::POWER_WIDTH-1:0];
			if (wr_xcvr) begin
				pulldown_disable <= reg_wdata[usb_ifm_pkg::XC_PD_DIS];
				filt_log2 <= reg_wdata[usb_ifm_pkg::XC_FILT_LO +: 4];
				resume_auto_en <= reg_wdata[usb_ifm_pkg::XC_RESUME_EN];
				transceiver_config_pins <= reg_wdata[usb_ifm_pkg::XC_CONF_LO +: 3];
			end
		end
	end

	// Resume cause bits: hardware set wins over a written zero
	wire next_res_se0 = (resume_se0 & resume_auto_en)
		| (res_se0 & ~(wr_xcvr & ~reg_wdata[usb_ifm_pkg::XC_RES_SE0]));
	wire next_res_k = (resume_k & resume_auto_en)
		| (res_k & ~(wr_xcvr & ~reg_wdata[usb_ifm_pkg::XC_RES_K]));

	always_ff @(posedge core_clk) begin
		if (state_rst) begin
			res_se0 <= 1'b0;
			res_k   <= 1'b0;
		end else begin
			res_se0 <= next_res_se0;
			res_k   <= next_res_k;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Packet capture and mirrors

	// A software write to the frame counter yields to an arriving SOF
	always_ff @(posedge core_clk) begin
		if (state_rst) begin
			frame_counter      <= '0;
			last_packet_id     <= '0;
			last_endpoint      <= '0;
			rx_endpoint        <= '0;
			rx_endpoint_strobe <= 1'b0;
		end else begin
			if (sof_valid)
				frame_counter <= sof_frame;
			else if (wr_frame)
				frame_counter <= reg_wdata[10:0];
			if (pkt_start)
				last_packet_id <= pkt_pid;
			if (token_ok) begin
				last_endpoint <= {1'b1, token.endp};
				rx_endpoint <= {endpoint_special_mask[token.endp] ? usb_ifm_pkg::EP_SPECIAL[4]
					: 1'b0, token.endp};
			end
			rx_endpoint_strobe <= token_ok;
		end
	end

	// Transceiver status copies
	always_ff @(posedge core_clk) begin
		if (state_rst) begin
			otg_status_flags <= '0;
			rx_line_status   <= '0;
		end else begin
			otg_status_flags <= utmi.otg;
			rx_line_status   <= {utmi.rx_rcv, utmi.rx_dm, utmi.rx_dp};
		end
	end

	// Transmit pin drive and port outputs
	always_ff @(posedge core_clk) begin
		if (state_rst) begin
			tx_se0        <= 1'b0;
			tx_data       <= 1'b0;
			tx_enable_sel <= 1'b0;
			fsls_serial   <= 1'b0;
			flag_port     <= '0;
		end else begin
			tx_se0        <= serial_line_control[usb_ifm_pkg::SER_TXSE0];
			tx_data       <= serial_line_control[usb_ifm_pkg::SER_TXDATA];
			tx_enable_sel <= ~serial_line_control[usb_ifm_pkg::SER_TXEN_N];
			fsls_serial   <= serial_line_control[usb_ifm_pkg::SER_FSLS];
			flag_port     <= next_flag_port;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path

	// Unmapped and write-only offsets read as zero, as do reserved bits
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (reg_addr)
			usb_ifm_pkg::OFF_DEVICE_ADDRESS:   rd_mux[6:0] = device_address;
			usb_ifm_pkg::OFF_OTG_STATUS:       rd_mux[5:0] = otg_status_flags;
			usb_ifm_pkg::OFF_SERIAL_LINE:      rd_mux[6:0] = {rx_line_status,
				serial_line_control};
			usb_ifm_pkg::OFF_EVENT_FLAGS:      rd_mux[6:0] = event_flag_vector;
			usb_ifm_pkg::OFF_FLAG_STICKINESS:  rd_mux[6:0] = flag_stickiness_select;
			usb_ifm_pkg::OFF_FLAG_PORT_MASKS:  rd_mux = flag_port_masks;
			usb_ifm_pkg::OFF_FRAME_COUNTER:    rd_mux[10:0] = frame_counter;
			usb_ifm_pkg::OFF_LAST_PACKET_ID:   rd_mux[3:0] = last_packet_id;
			usb_ifm_pkg::OFF_LAST_ENDPOINT:    rd_mux[4:0] = last_endpoint;
			usb_ifm_pkg::OFF_ENDPOINT_SPECIAL: rd_mux[15:0] = endpoint_special_mask;
			usb_ifm_pkg::OFF_OTG_EVENT_MASK:   rd_mux = otg_event_mask;
			usb_ifm_pkg::OFF_POWER_SIGNAL:     rd_mux[8:0] = power_signal_word;
			usb_ifm_pkg::OFF_XCVR_CONTROL:     rd_mux[18:4] = {pulldown_disable, 4'h0,
				res_se0, res_k, filt_log2, resume_auto_en, transceiver_config_pins};
			default:                           rd_mux = '0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata  <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata  <= reg_rd ? rd_mux : '0;
			reg_rvalid <= reg_rd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst || soft_rst);

	token_flag_a: assert property (token_ok && !soft_rst |=> event_flag_vector[6])
		else $error("token flag not set");
	crc_flag_a: assert property (crc16_fail |=> event_flag_vector[2])
		else $error("crc16 flag not set");
	rx_follow_a: assert property (!flag_stickiness_select[1] |=>
		event_flag_vector[1] == $past(utmi.rx_active))
		else $error("rx active flag not following input");
	sticky_hold_a: assert property (flag_stickiness_select[6] && event_flag_vector[6]
		&& !(wr_flags && reg_wdata[6]) |=> event_flag_vector[6])
		else $error("sticky flag lost");
	port_or_a: assert property ($changed(event_flag_vector) && !wr_masks |=>
		flag_port[0] == |($past(event_flag_vector) & flag_port_masks[6:0]))
		else $error("port output not OR of masked flags");
	special_ep_a: assert property (token_ok |=> rx_endpoint_strobe
		&& rx_endpoint == {$past(endpoint_special_mask[token.endp]), $past(token.endp)})
		else $error("endpoint delivery wrong");
	resume_k_a: assert property (resume_k && resume_auto_en |=> res_k)
		else $error("resume K bit not set");
	// A set cause bit may only fall on a written zero
	res_k_hold_a: assert property (res_k
		&& !(wr_xcvr && !reg_wdata[usb_ifm_pkg::XC_RES_K]) |=> res_k)
		else $error("resume K bit lost");
	resume_gate_a: assert property (!resume_auto_en && !res_se0 |=> !res_se0)
		else $error("resume cause set while hardware handling off");
	pid_capture_a: assert property (pkt_start |=> last_packet_id == $past(pkt_pid))
		else $error("packet id not captured");
	config_pins_a: assert property (wr_xcvr |=>
		transceiver_config_pins == $past(reg_wdata[6:4]))
		else $error("config pins not driven");
	soft_reset_a: assert property (@(posedge core_clk) disable iff (rst)
		wr_reset |=> ##1 event_flag_vector == '0 && device_address == '0)
		else $error("module reset did not clear state");
	frame_write_a: assert property (wr_frame && !sof_valid |=>
		frame_counter == $past(reg_wdata[10:0]))
		else $error("frame counter write lost");
	ep_valid_a: assert property (token_ok |=>
		last_endpoint == {1'b1, $past(token.endp)})
		else $error("last endpoint not captured");
	addr_match_a: assert property (token.valid && token.addr != device_address
		|=> !rx_endpoint_strobe)
		else $error("token to foreign address delivered");
	tx_enable_a: assert property (wr_serial |=> ##1
		tx_enable_sel == !$past(reg_wdata[usb_ifm_pkg::SER_TXEN_N], 2))
		else $error("transmit enable pin wrong");

endmodule

// ### verilog/usb_ifm_pkg.sv
// Register map, field positions and carrier types for the USB interface flag logic
package usb_ifm_pkg;
	// Register offsets
	localparam logic [7:0] OFF_MODULE_RESET     = 8'h00;
	localparam logic [7:0] OFF_DEVICE_ADDRESS   = 8'h08;
	localparam logic [7:0] OFF_OTG_STATUS       = 8'h14;
	localparam logic [7:0] OFF_SERIAL_LINE      = 8'h18;
	localparam logic [7:0] OFF_EVENT_FLAGS      = 8'h1c;
	localparam logic [7:0] OFF_FLAG_STICKINESS  = 8'h20;
	localparam logic [7:0] OFF_FLAG_PORT_MASKS  = 8'h24;
	localparam logic [7:0] OFF_FRAME_COUNTER    = 8'h28;
	localparam logic [7:0] OFF_LAST_PACKET_ID   = 8'h2c;
	localparam logic [7:0] OFF_LAST_ENDPOINT    = 8'h30;
	localparam logic [7:0] OFF_ENDPOINT_SPECIAL = 8'h34;
	localparam logic [7:0] OFF_OTG_EVENT_MASK   = 8'h38;
	localparam logic [7:0] OFF_POWER_SIGNAL     = 8'h3c;
	localparam logic [7:0] OFF_XCVR_CONTROL     = 8'h40;

	// Event flag positions
	localparam int FLAG_RXERROR = 0;
	localparam int FLAG_RXACTIVE = 1;
	localparam int FLAG_CRC16 = 2;
	localparam int FLAG_J = 3;
	localparam int FLAG_K = 4;
	localparam int FLAG_SE0 = 5;
	localparam int FLAG_TOKEN = 6;
	localparam int NUM_FLAGS = 7;
	// Flags that track a level rather than latch a pulse
	localparam logic [6:0] LEVEL_FLAGS = 7'h3b;

	// Serial line control fields
	localparam int SER_FSLS = 0;
	localparam int SER_TXEN_N = 1;
	localparam int SER_TXDATA = 2;
	localparam int SER_TXSE0 = 3;
	localparam logic [3:0] SER_RESET = 4'h2;

	// Transceiver control fields
	localparam int XC_CONF_LO = 4;
	localparam int XC_RESUME_EN = 7;
	localparam int XC_FILT_LO = 8;
	localparam int XC_RES_K = 12;
	localparam int XC_RES_SE0 = 13;
	localparam int XC_PD_DIS = 18;

	// Endpoint register and port fields, power signal word width
	localparam int EP_VALID = 4;
	localparam logic [4:0] EP_SPECIAL = 5'h10;
	localparam int POWER_WIDTH = 9;

	// Decoded line states
	localparam logic [1:0] LS_SE0 = 2'h0;
	localparam logic [1:0] LS_J = 2'h1;
	localparam logic [1:0] LS_K = 2'h2;

	// Transceiver inputs sampled by the block
	typedef struct packed {
		logic [5:0] otg;
		logic       rx_rcv;
		logic       rx_dm;
		logic       rx_dp;
		logic       rx_active;
		logic       rx_error;
		logic [1:0] linestate;
	} utmi_in_t;

	// Decoded token from the packet datapath
	typedef struct packed {
		logic       valid;
		logic       crc5_ok;
		logic       pid_ok;
		logic [6:0] addr;
		logic [3:0] endp;
	} token_t;
endpackage

// ### test/usb_far_side_model.sv
// Far-side model: transceiver levels, packet datapath and suspend controller pulses
`timescale 1ns/1ps

module usb_far_side_model (
	input  wire logic          core_clk,
	output usb_ifm_pkg::utmi_in_t utmi,
	output usb_ifm_pkg::token_t   token,
	output logic               pkt_start,
	output logic [3:0]         pkt_pid,
	output logic               crc16_fail,
	output logic               sof_valid,
	output logic [10:0]        sof_frame,
	output logic               resume_se0,
	output logic               resume_k
);
	// Idle values; data lines never hold their last value once released
	initial begin
		utmi = '0;
		utmi.linestate = usb_ifm_pkg::LS_J;
		token = 14'h2aaa;
		{pkt_start, crc16_fail, sof_valid, resume_se0, resume_k} = '0;
		pkt_pid = 4'h5;
		sof_frame = 11'h555;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Level changes land off the sampling edge
	task automatic set_utmi(input usb_ifm_pkg::utmi_in_t v);
		@(negedge core_clk);
		utmi = v;
	endtask

	// Token pulse; fields invert afterwards so stale values cannot pass
	task automatic send_token(input logic [6:0] a, input logic [3:0] ep, input logic ok);
		@(negedge core_clk);
		token = {1'b1, ok, 1'b1, a, ep};
		@(negedge core_clk);
		token = ~token;
	endtask

	task automatic send_pkt(input logic [3:0] pid);
		@(negedge core_clk);
		pkt_start = 1'b1;
		pkt_pid = pid;
		@(negedge core_clk);
		pkt_start = 1'b0;
		pkt_pid = ~pid;
	endtask

	task automatic send_crc_fail();
		@(negedge core_clk);
		crc16_fail = 1'b1;
		@(negedge core_clk);
		crc16_fail = 1'b0;
	endtask

	task automatic send_sof(input logic [10:0] f);
		@(negedge core_clk);
		sof_valid = 1'b1;
		sof_frame = f;
		@(negedge core_clk);
		sof_valid = 1'b0;
		sof_frame = ~f;
	endtask

	// Suspend controller reports the kind of resume signalling seen
	task automatic send_resume(input logic is_se0);
		@(negedge core_clk);
		resume_se0 = is_se0;
		resume_k = ~is_se0;
		@(negedge core_clk);
		{resume_se0, resume_k} = 2'b00;
	endtask
endmodule

// ### test/test_usb_interface_module.sv
// Self-checking bench for the USB interface flag and control registers
`timescale 1ns/1ps

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end

module test_usb_interface_module;
	logic core_clk = 1'b0;
	logic rst;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic reg_rvalid, rx_endpoint_strobe, tx_se0, tx_data, tx_enable_sel, fsls_serial;
	logic pulldown_disable, resume_auto_en;
	logic [3:0] flag_port;
	logic [4:0] rx_endpoint;
	logic [4:0] last_ep = 5'h0;
	logic [1:0] linestate_filtered;
	logic [2:0] transceiver_config_pins;
	usb_ifm_pkg::utmi_in_t utmi, u;
	usb_ifm_pkg::token_t token;
	logic pkt_start, crc16_fail, sof_valid, resume_se0, resume_k;
	logic [3:0] pkt_pid;
	logic [10:0] sof_frame;
	int n_mismatch = 0;
	int num_checks = 0;
	int n_strobe = 0;
	logic [7:0] zero_regs [10] = '{8'h14, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38,
		8'h3c, 8'h40};
	localparam logic [31:0] XC = 32'h0004_03d0;

	usb_interface_module dut_u (.*);
	usb_far_side_model far_u (.*);

	always #5 core_clk = ~core_clk;

	// Count endpoint deliveries so missing or extra strobes show up
	always @(posedge core_clk) begin
		if (rx_endpoint_strobe === 1'b1) begin
			n_strobe++;
			last_ep = rx_endpoint;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Whole 32-bit words only; strobe held across exactly one sampling edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge core_clk);
		{reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge core_clk);
		{reg_rd, reg_addr} = {1'b1, a};
		@(negedge core_clk);
		reg_rd = 1'b0;
		`CHK(reg_rvalid, 1'b1)
		`CHK(reg_rdata, e)
	endtask

	task automatic summarize();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog sized well above the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 1'b0, 1'b0, 8'h00, 32'h0};
		u = '0;
		u.linestate = usb_ifm_pkg::LS_J;
		idle(5);
		rst = 1'b0;
		foreach (zero_regs[i]) rd(zero_regs[i], 32'h0);
		rd(8'h18, 32'h2);
		rd(8'h1c, 32'h08);
		rd(8'h44, 32'h0);
		`CHK(tx_enable_sel, 1'b0)
		// Mirrors of receive and on-the-go levels
		u.otg = 6'h2a;
		{u.rx_rcv, u.rx_dm, u.rx_dp} = 3'b101;
		far_u.set_utmi(u);
		idle(2);
		rd(8'h14, 32'h2a);
		rd(8'h18, 32'h52);
		wr(8'h18, 32'hffff_fffd);
		rd(8'h18, 32'h5d);
		idle(2);
		`CHK({tx_se0, tx_data, tx_enable_sel, fsls_serial}, 4'hf)
		// Control word with reserved bits set, filter of 8 cycles
		wr(8'h40, 32'hfffc_03df);
		rd(8'h40, XC);
		idle(2);
		`CHK({pulldown_disable, resume_auto_en, transceiver_config_pins}, 5'b11101)
		u.linestate = usb_ifm_pkg::LS_K;
		far_u.set_utmi(u);
		idle(4);
		`CHK(linestate_filtered, usb_ifm_pkg::LS_J)
		idle(10);
		`CHK(linestate_filtered, usb_ifm_pkg::LS_K)
		// A short glitch must be filtered out
		u.linestate = usb_ifm_pkg::LS_SE0;
		far_u.set_utmi(u);
		idle(2);
		u.linestate = usb_ifm_pkg::LS_K;
		far_u.set_utmi(u);
		idle(14);
		`CHK(linestate_filtered, usb_ifm_pkg::LS_K)
		u.linestate = usb_ifm_pkg::LS_SE0;
		far_u.set_utmi(u);
		idle(14);
		rd(8'h1c, 32'h20);
		// Resume reporting only while hardware handling is on
		far_u.send_resume(1'b1);
		rd(8'h40, XC | 32'h2000);
		wr(8'h40, XC | 32'h2000);
		rd(8'h40, XC | 32'h2000);
		wr(8'h40, XC);
		far_u.send_resume(1'b0);
		rd(8'h40, XC | 32'h1000);
		wr(8'h40, XC & ~32'h80);
		far_u.send_resume(1'b1);
		rd(8'h40, XC & ~32'h80);
		// Port masks: error, active, token, crc
		wr(8'h24, 32'h8440_8281);
		rd(8'h24, 32'h0440_0201);
		u.rx_error = 1'b1;
		far_u.set_utmi(u);
		idle(3);
		`CHK(flag_port, 4'h1)
		rd(8'h1c, 32'h21);
		{u.rx_error, u.rx_active} = 2'b01;
		far_u.set_utmi(u);
		idle(3);
		`CHK(flag_port, 4'h2)
		u.rx_active = 1'b0;
		far_u.set_utmi(u);
		far_u.send_crc_fail();
		idle(3);
		`CHK(flag_port, 4'h8)
		far_u.send_pkt(4'hd);
		idle(2);
		rd(8'h1c, 32'h20);
		rd(8'h2c, 32'hd);
		// Tokens: accepted, wrong address, bad check
		far_u.send_token(7'h00, 4'h5, 1'b1);
		idle(2);
		`CHK(flag_port, 4'h4)
		rd(8'h30, 32'h15);
		far_u.send_token(7'h03, 4'h6, 1'b1);
		far_u.send_token(7'h00, 4'h7, 1'b0);
		idle(2);
		`CHK(n_strobe, 1)
		`CHK(last_ep, 5'h05)
		wr(8'h34, 32'hffff_0200);
		rd(8'h34, 32'h200);
		wr(8'h08, 32'h2a);
		far_u.send_token(7'h2a, 4'h9, 1'b1);
		idle(2);
		`CHK(n_strobe, 2)
		`CHK(last_ep, 5'h19)
		// Sticky crc flag survives a packet until written with one
		wr(8'h20, 32'h04);
		far_u.send_crc_fail();
		far_u.send_pkt(4'h3);
		rd(8'h1c, 32'h24);
		wr(8'h1c, 32'h04);
		rd(8'h1c, 32'h20);
		wr(8'h28, 32'hffff_fabc);
		rd(8'h28, 32'h2bc);
		far_u.send_sof(11'h5a3);
		rd(8'h28, 32'h5a3);
		wr(8'h2c, 32'hf);
		rd(8'h2c, 32'h3);
		wr(8'h38, 32'hffff_ffff);
		rd(8'h38, 32'hffff_ffff);
		wr(8'h3c, 32'hffff_ffff);
		rd(8'h3c, 32'h1ff);
		// Module soft reset clears state; the receive mirrors reload from the lines right after
		wr(8'h00, 32'h0);
		idle(3);
		rd(8'h28, 32'h0);
		rd(8'h20, 32'h0);
		rd(8'h40, 32'h0);
		rd(8'h18, 32'h52);
		`CHK(pulldown_disable, 1'b0)
		summarize();
	end
endmodule
